// File: hw/angle_enc_pkg.sv
package angle_enc_pkg;

  // Angle, frame and store word widths
  localparam int ANGLE_W = 12;
  localparam int FRAME_W = 16;
  localparam int NVM_W   = 24;

  // Configuration addresses carried in a write frame
  localparam logic [2:0] ADDR_ZERO = 3'h0;
  localparam logic [2:0] ADDR_PP   = 3'h1;
  localparam logic [2:0] ADDR_PPR  = 3'h2;
  localparam logic [2:0] ADDR_CTL  = 3'h3;

  // Frame field positions
  localparam int FR_WR_BIT   = 15;
  localparam int FR_ADDR_LSB = 12;
  localparam int CTL_DIFF    = 0;
  localparam int CTL_COMMIT  = 1;

  // Non-volatile word layout
  localparam int NVM_ZERO_LSB = 0;
  localparam int NVM_PP_LSB   = 12;
  localparam int NVM_PPR_LSB  = 15;
  localparam int NVM_DIFF_BIT = 23;

  // Values forced in the fixed variant
  localparam logic [2:0] FIXED_PP_M1  = 3'h0;
  localparam logic [7:0] FIXED_PPR_M1 = 8'hFF;

  // Field strength limits on the magnitude input
  localparam logic [7:0] FIELD_LOW_TH  = 8'h20;
  localparam logic [7:0] FIELD_HIGH_TH = 8'hE0;

  // Remainder of an electrical sector index by six
  function automatic logic [2:0] mod_six(input logic [5:0] idx);
    logic [5:0] r;
    r = idx;
    for (int k = 0; k < 8; k++)
    begin
      if (r >= 6'd6)
      begin
        r = r - 6'd6;
      end
    end
    return r[2:0];
  endfunction : mod_six

  // Six-step Hall pattern, one bit changes per step
  function automatic logic [2:0] hall_code(input logic [2:0] st);
    logic [2:0] h;
    h = 3'h5;
    case (st)
      3'd0: h = 3'h5;
      3'd1: h = 3'h4;
      3'd2: h = 3'h6;
      3'd3: h = 3'h2;
      3'd4: h = 3'h3;
      default: h = 3'h1;
    endcase
    return h;
  endfunction : hall_code

endpackage : angle_enc_pkg

// File: hw/uvw_sector.sv
`timescale 1ns/1ps
module uvw_sector
  import angle_enc_pkg::*;
(
  // Corrected angle and pole pair setting
  input  wire logic [ANGLE_W-1:0] angle_i,
  input  wire logic [2:0]         pp_m1_i,
  // Hall pattern
  output logic      [2:0]         hall_o
);

  logic [5:0]  states;
  logic [17:0] prod;
  logic [5:0]  idx;

  // Sector index is angle times state count over one turn
  assign states = 6'(({3'h0, pp_m1_i} + 6'd1) * 6'd6);
  assign prod   = {6'h00, angle_i} * {12'h000, states};
  assign idx    = prod[17:12];
  assign hall_o = hall_code(mod_six(idx));

endmodule : uvw_sector

// File: hw/abz_quad.sv
`timescale 1ns/1ps
module abz_quad
  import angle_enc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               ce_i,
  // Corrected angle and pulses per channel minus one
  input  wire logic [ANGLE_W-1:0] angle_i,
  input  wire logic [7:0]         ppr_m1_i,
  // Quadrature outputs
  output logic                    a_o,
  output logic                    b_o,
  output logic                    z_o
);

  logic [10:0] modulus;
  logic [22:0] prod;
  logic [9:0]  target;
  logic [9:0]  pos_q;
  logic [9:0]  pos_d;
  logic [10:0] diff;
  logic        step_up;

  // Edges per turn is four per pulse
  assign modulus = {1'b0, ({2'b00, ppr_m1_i} + 10'd1)} << 2;
  assign prod    = {11'h000, angle_i} * {12'h000, modulus};
  assign target  = prod[21:12];
  assign diff    = (target >= pos_q) ? 11'({1'b0, target} - {1'b0, pos_q})
                 : 11'({1'b0, target} + modulus - {1'b0, pos_q});
  assign step_up = diff < (modulus >> 1);

  // One edge per clock toward the target so A and B never move together, except a position past the modulus jumps straight to the target
  always_comb
  begin
    pos_d = pos_q;
    if ({1'b0, pos_q} >= modulus)
    begin
      pos_d = target;
    end
    else if (diff != 11'h000)
    begin
      if (step_up)
      begin
        pos_d = ({1'b0, pos_q} + 11'd1 == modulus) ? 10'h000 : pos_q + 10'd1;
      end
      else
      begin
        pos_d = (pos_q == 10'h000) ? 10'(modulus - 11'd1) : pos_q - 10'd1;
      end
    end
  end

  // Position counter and registered outputs
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pos_q <= 10'h000;
      a_o   <= 1'b0;
      b_o   <= 1'b0;
      z_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      pos_q <= pos_d;
      a_o   <= pos_d[1] ^ pos_d[0];
      b_o   <= pos_d[1];
      z_o   <= (pos_d == 10'h000);
    end
  end

endmodule : abz_quad

// File: hw/angle_to_commutation_encoder.sv
`timescale 1ns/1ps
module angle_to_commutation_encoder
  import angle_enc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       ce_i,
  // Variant straps, caught after reset release
  input  wire logic                       fixed_variant_i,
  input  wire logic                       res11_variant_i,
  input  wire logic                       otp_variant_i,
  // Measured angle and field magnitude
  input  wire logic [angle_enc_pkg::ANGLE_W-1:0] angle_i,
  input  wire logic [7:0]                 field_mag_i,
  // Non-volatile store
  input  wire logic [angle_enc_pkg::NVM_W-1:0]   nvm_rd_data_i,
  input  wire logic                       nvm_blown_i,
  output logic      [angle_enc_pkg::NVM_W-1:0]   nvm_wr_data_o,
  output logic                            nvm_wr_o,
  // SPI port
  input  wire logic                       sck_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       mosi_i,
  output logic                            miso_o,
  output logic                            miso_oe_n_o,
  // Commutation outputs
  output logic      [2:0]                 uvw_o,
  output logic      [2:0]                 uvw_n_o,
  // Incremental encoder outputs
  output logic                            a_o,
  output logic                            b_o,
  output logic                            z_o,
  // Status
  output logic                            field_low_o,
  output logic                            field_high_o,
  output logic                            nvm_locked_o
);

  // Configuration state
  logic                   loaded_q;
  logic                   fixed_q;
  logic                   res11_q;
  logic                   otp_q;
  logic [ANGLE_W-1:0]     zero_q;
  logic [2:0]             pp_m1_q;
  logic [7:0]             ppr_m1_q;
  logic                   diff_en_q;
  logic                   burnt_q;

  // SPI state
  logic                   sck_q;
  logic                   cs_n_q;
  logic [FRAME_W-1:0]     shin_q;
  logic [FRAME_W-1:0]     shout_q;
  logic [4:0]             bit_cnt_q;

  // Decoded wires
  logic                   sck_rise;
  logic                   sck_fall;
  logic                   cs_fall;
  logic                   frame_done;
  logic [FRAME_W-1:0]     frame_word;
  logic                   frame_wr;
  logic [2:0]             frame_addr;
  logic [ANGLE_W-1:0]     frame_data;
  logic                   wr_zero;
  logic                   wr_pp;
  logic                   wr_ppr;
  logic                   wr_ctl;
  logic                   commit_req;
  logic                   commit_ok;
  logic [ANGLE_W-1:0]     angle_corr;
  logic [ANGLE_W-1:0]     angle_spi;
  logic [2:0]             pp_m1_eff;
  logic [7:0]             ppr_m1_eff;
  logic [2:0]             hall;
  logic [FRAME_W-1:0]     resp_word;
  logic                   field_low_d;
  logic                   field_high_d;
  logic                   store_locked;
  logic [2:0]             uvw_n_d;

  // Offset the measured angle by the stored zero position
  assign angle_corr = angle_i - zero_q;

  // Fixed variant ignores programmable steps and resolution
  assign pp_m1_eff  = fixed_q ? FIXED_PP_M1 : pp_m1_q;
  assign ppr_m1_eff = fixed_q ? FIXED_PPR_M1 : ppr_m1_q;

  // Base variant drops the lowest angle bit on SPI
  assign angle_spi  = res11_q ? {angle_corr[ANGLE_W-1:1], 1'b0} : angle_corr;

  // Field limits, only in later variants
  assign field_low_d  = ~res11_q & (field_mag_i < FIELD_LOW_TH);
  assign field_high_d = ~res11_q & (field_mag_i > FIELD_HIGH_TH);

  // SPI edge and frame decode
  assign sck_rise   = ~cs_n_i & sck_i & ~sck_q;
  assign sck_fall   = ~cs_n_i & ~sck_i & sck_q;
  assign cs_fall    = ~cs_n_i & cs_n_q;
  assign frame_done = sck_rise & (bit_cnt_q == 5'(FRAME_W - 1));
  assign frame_word = {shin_q[FRAME_W-2:0], mosi_i};
  assign frame_wr   = frame_done & frame_word[FR_WR_BIT];
  assign frame_addr = frame_word[FR_WR_BIT-1:FR_ADDR_LSB];
  assign frame_data = frame_word[ANGLE_W-1:0];

  // Write decode by address
  assign wr_zero    = frame_wr & (frame_addr == ADDR_ZERO);
  assign wr_pp      = frame_wr & (frame_addr == ADDR_PP) & ~fixed_q;
  assign wr_ppr     = frame_wr & (frame_addr == ADDR_PPR) & ~fixed_q;
  assign wr_ctl     = frame_wr & (frame_addr == ADDR_CTL);
  assign commit_req = wr_ctl & frame_data[CTL_COMMIT];
  assign commit_ok  = commit_req & ~store_locked;

  // A one-time store refuses any further burn once written
  assign store_locked = otp_q & burnt_q;

  // Complement lines stay low unless differential drive is on
  assign uvw_n_d    = diff_en_q ? ~hall : 3'h0;

  // Answer word: angle, field flags, store lock
  assign resp_word  = {angle_spi, field_low_o, field_high_o, store_locked, 1'b0};

  // Sector to Hall pattern
  uvw_sector u_sector
  (
    .angle_i (angle_corr),
    .pp_m1_i (pp_m1_eff),
    .hall_o  (hall)
  );

  // Quadrature generator
  abz_quad u_abz
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .angle_i   (angle_corr),
    .ppr_m1_i  (ppr_m1_eff),
    .a_o       (a_o),
    .b_o       (b_o),
    .z_o       (z_o)
  );

  // Straps and stored settings load once after reset release
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      loaded_q <= 1'b0;
      fixed_q  <= 1'b0;
      res11_q  <= 1'b0;
      otp_q    <= 1'b0;
    end
    else if (ce_i & ~loaded_q)
    begin
      loaded_q <= 1'b1;
      fixed_q  <= fixed_variant_i;
      res11_q  <= res11_variant_i;
      otp_q    <= otp_variant_i;
    end
  end

  // Configuration registers, shadowed from the store then written over SPI
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      zero_q    <= 12'h000;
      pp_m1_q   <= 3'h0;
      ppr_m1_q  <= 8'hFF;
      diff_en_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (~loaded_q)
      begin
        zero_q    <= nvm_rd_data_i[NVM_ZERO_LSB +: ANGLE_W];
        pp_m1_q   <= nvm_rd_data_i[NVM_PP_LSB +: 3];
        ppr_m1_q  <= nvm_rd_data_i[NVM_PPR_LSB +: 8];
        diff_en_q <= nvm_rd_data_i[NVM_DIFF_BIT];
      end
      else
      begin
        if (wr_zero)
        begin
          zero_q <= frame_data;
        end
        if (wr_pp)
        begin
          pp_m1_q <= frame_data[2:0];
        end
        if (wr_ppr)
        begin
          ppr_m1_q <= frame_data[7:0];
        end
        if (wr_ctl)
        begin
          diff_en_q <= frame_data[CTL_DIFF];
        end
      end
    end
  end

  // Store commit; one-time store locks after its first burn
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      burnt_q       <= 1'b0;
      nvm_wr_o      <= 1'b0;
      nvm_wr_data_o <= '0;
    end
    else if (ce_i)
    begin
      if (~loaded_q)
      begin
        burnt_q <= nvm_blown_i;
      end
      else if (commit_ok)
      begin
        burnt_q <= 1'b1;
      end
      nvm_wr_o <= loaded_q & commit_ok;
      if (loaded_q & commit_ok)
      begin
        nvm_wr_data_o <= {frame_data[CTL_DIFF], ppr_m1_q, pp_m1_q, zero_q};
      end
    end
  end

  // SPI shift engine: sample on rising clock, shift out on falling
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sck_q     <= 1'b0;
      cs_n_q    <= 1'b1;
      shin_q    <= '0;
      shout_q   <= '0;
      bit_cnt_q <= 5'h00;
    end
    else if (ce_i)
    begin
      sck_q  <= sck_i;
      cs_n_q <= cs_n_i;
      if (cs_fall)
      begin
        shout_q   <= resp_word;
        bit_cnt_q <= 5'h00;
      end
      else
      begin
        if (sck_rise)
        begin
          shin_q    <= frame_word;
          bit_cnt_q <= frame_done ? 5'h00 : bit_cnt_q + 5'd1;
        end
        if (sck_fall)
        begin
          shout_q <= {shout_q[FRAME_W-2:0], 1'b0};
        end
      end
    end
  end

  // SPI output pin, enabled low while selected
  assign miso_o      = shout_q[FRAME_W-1];
  assign miso_oe_n_o = cs_n_q;

  // Commutation outputs and their optional complements
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      uvw_o   <= 3'h0;
      uvw_n_o <= 3'h0;
    end
    else if (ce_i)
    begin
      uvw_o   <= hall;
      uvw_n_o <= uvw_n_d;
    end
  end

  // Field status flags, registered so the host sees clean levels
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      field_low_o  <= 1'b0;
      field_high_o <= 1'b0;
    end
    else if (ce_i)
    begin
      field_low_o  <= field_low_d;
      field_high_o <= field_high_d;
    end
  end

  // Lock state shown to the outside
  assign nvm_locked_o = store_locked;

endmodule : angle_to_commutation_encoder

// File: sim/angle_enc_assertions.sv
`timescale 1ns/1ps
module angle_enc_assertions
  import angle_enc_pkg::*;
(
  // Clock, reset, enable
  input wire logic                               clk_i,
  input wire logic                               sys_rst_i,
  input wire logic                               ce_i,
  // Inputs watched
  input wire logic [angle_enc_pkg::ANGLE_W-1:0]  angle_i,
  input wire logic [7:0]                         field_mag_i,
  input wire logic                               cs_n_i,
  // Outputs watched
  input wire logic                               miso_oe_n_o,
  input wire logic                               nvm_wr_o,
  input wire logic [2:0]                         uvw_o,
  input wire logic [2:0]                         uvw_n_o,
  input wire logic                               a_o,
  input wire logic                               b_o,
  input wire logic                               z_o,
  input wire logic                               field_low_o,
  input wire logic                               field_high_o
);
  logic [2:0] quiet_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Clocks since select was low, so a configuration write has settled
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      quiet_q <= 3'h0;
    else if (!cs_n_i)
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7)
      quiet_q <= quiet_q + 3'h1;

  uvw_hold_a: assert property (quiet_q == 3'h7 && $past(uvw_o, 2) != 3'h0
    && $past(angle_i) == $past(angle_i, 2) |-> $stable(uvw_o))
    else $error("commutation moved with a still angle");
  uvw_legal_a: assert property ($past(uvw_o) != 3'h0
    |-> uvw_o != 3'h0 && uvw_o != 3'h7)
    else $error("commutation code out of the six-step set");
  uvw_step_a: assert property (quiet_q == 3'h7 && $past(uvw_o, 2) != 3'h0
    && 12'($past(angle_i) - $past(angle_i, 2)) inside {12'h000, 12'h001, 12'hFFF}
    |-> $countones(uvw_o ^ $past(uvw_o)) <= 1)
    else $error("commutation changed more than one line");
  diff_copy_a: assert property (uvw_n_o != 3'h0 |-> uvw_n_o == ~uvw_o)
    else $error("complement lines disagree");
  quad_gray_a: assert property (!($changed(a_o) && $changed(b_o)))
    else $error("both quadrature lines changed at once");
  index_pos_a: assert property (z_o |-> !a_o && !b_o)
    else $error("index outside position zero");
  oe_follow_a: assert property (miso_oe_n_o == $past(cs_n_i))
    else $error("serial output enable does not follow select");
  commit_pulse_a: assert property (nvm_wr_o |=> !nvm_wr_o)
    else $error("store write longer than one clock");
  field_low_a: assert property (field_low_o |-> $past(field_mag_i) <= FIELD_LOW_TH)
    else $error("weak field flag with strong field");
  field_high_a: assert property (field_high_o |-> $past(field_mag_i) >= FIELD_HIGH_TH)
    else $error("strong field flag with weak field");

  // Main scenarios reached
  cover property ($rose(z_o));
  cover property (nvm_wr_o);
  cover property (uvw_n_o != 3'h0);
endmodule : angle_enc_assertions

bind angle_to_commutation_encoder angle_enc_assertions chk (.clk_i, .sys_rst_i, .ce_i,
  .angle_i, .field_mag_i, .cs_n_i, .miso_oe_n_o, .nvm_wr_o, .uvw_o, .uvw_n_o, .a_o, .b_o,
  .z_o, .field_low_o, .field_high_o);

// File: sim/motor_ctrl_model.sv
`timescale 1ns/1ps
module motor_ctrl_model
(
  // Clock, reset, counter clear
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clr_i,
  // Lines from the sensor
  input  wire logic [2:0] uvw_i,
  input  wire logic       a_i,
  input  wire logic       b_i,
  input  wire logic       z_i,
  // Decoded counts
  output int              pos_o,
  output int              bad_o,
  output int              steps_o,
  output int              zrise_o
);
  logic [1:0] ph_q;
  logic [2:0] uvw_q;
  logic       z_q;
  logic [1:0] ph;
  logic [1:0] dph;

  // Quadrature phase number and its change since last clock
  assign ph  = {b_i, a_i ^ b_i};
  assign dph = ph - ph_q;

  // Sample every clock like the drive does, and count moves
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      ph_q    <= 2'h0;
      uvw_q   <= 3'h0;
      z_q     <= 1'b0;
      pos_o   <= 0;
      bad_o   <= 0;
      steps_o <= 0;
      zrise_o <= 0;
    end
    else if (clr_i)
    begin
      ph_q    <= ph;
      uvw_q   <= uvw_i;
      z_q     <= z_i;
      pos_o   <= 0;
      bad_o   <= 0;
      steps_o <= 0;
      zrise_o <= 0;
    end
    else
    begin
      ph_q    <= ph;
      uvw_q   <= uvw_i;
      z_q     <= z_i;
      pos_o   <= pos_o + (dph == 2'h1) - (dph == 2'h3);
      bad_o   <= bad_o + (dph == 2'h2);
      steps_o <= steps_o + (uvw_i != uvw_q);
      zrise_o <= zrise_o + (z_i && !z_q);
    end
endmodule : motor_ctrl_model

// File: sim/tb_angle_to_commutation_encoder.sv
`timescale 1ns/1ps
module tb_angle_to_commutation_encoder;
  import angle_enc_pkg::*;
  // State 0 code in the low three bits
  localparam logic [17:0] HALL_SEQ = 18'h0B5A5;
  // Design pins and bench state
  logic               clk_i = 1'b0;
  logic               sys_rst_i = 1'b1;
  logic               ce_i = 1'b1;
  logic               fixed_variant_i = 1'b0, res11_variant_i = 1'b0, otp_variant_i = 1'b0;
  logic [ANGLE_W-1:0] angle_i = 12'h000;
  logic [7:0]         field_mag_i = 8'h80;
  logic [NVM_W-1:0]   nvm_rd_data_i = 24'h7F8000;
  logic               nvm_blown_i = 1'b0, sck_i = 1'b0, cs_n_i = 1'b1, mosi_i = 1'b0;
  logic [NVM_W-1:0]   nvm_wr_data_o, wr_data;
  logic [2:0]         uvw_o, uvw_n_o;
  logic               nvm_wr_o, miso_o, miso_oe_n_o, a_o, b_o, z_o, clr = 1'b0;
  logic               field_low_o, field_high_o, nvm_locked_o;
  int                 pos, bad, steps, zrise, wr_seen = 0, errors = 0, checks_done = 0;

  always #12.5 clk_i = ~clk_i;

  angle_to_commutation_encoder DUT (.clk_i, .sys_rst_i, .ce_i, .fixed_variant_i,
    .res11_variant_i, .otp_variant_i, .angle_i, .field_mag_i, .nvm_rd_data_i, .nvm_blown_i,
    .nvm_wr_data_o, .nvm_wr_o, .sck_i, .cs_n_i, .mosi_i, .miso_o, .miso_oe_n_o, .uvw_o,
    .uvw_n_o, .a_o, .b_o, .z_o, .field_low_o, .field_high_o, .nvm_locked_o);
  motor_ctrl_model ctrl (.clk_i, .sys_rst_i, .clr_i(clr), .uvw_i(uvw_o), .a_i(a_o),
    .b_i(b_o), .z_i(z_o), .pos_o(pos), .bad_o(bad), .steps_o(steps), .zrise_o(zrise));

  // Catch store write pulses
  always @(posedge clk_i)
    if (nvm_wr_o === 1'b1)
    begin
      wr_seen++;
      wr_data = nvm_wr_data_o;
    end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  function automatic logic [2:0] exp_uvw(input logic [11:0] ang, input int n);
    return HALL_SEQ[3 * ((int'(ang) * 6 * n / 4096) % 6) +: 3];
  endfunction : exp_uvw

  task automatic reset_dut(input logic fx, input logic r11, input logic otp);
    fixed_variant_i = fx;
    res11_variant_i = r11;
    otp_variant_i = otp;
    nvm_blown_i = otp;
    sys_rst_i = 1'b1;
    tick(8);
    chk(24'({uvw_o, uvw_n_o, a_o, b_o, z_o, miso_oe_n_o}), 24'h000001);
    sys_rst_i = 1'b0;
    tick(4);
  endtask : reset_dut

  // Mode 0 frame, MSB first, read bit taken before each rising clock
  task automatic spi(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_i = 1'b0;
    tick(3);
    for (int i = 15; i >= 0; i--)
    begin
      mosi_i = tx[i];
      rx[i] = miso_o;
      tick(1);
      sck_i = 1'b1;
      tick(3);
      sck_i = 1'b0;
      tick(3);
    end
    cs_n_i = 1'b1;
    tick(4);
  endtask : spi

  task automatic cfg(input logic [2:0] a, input logic [11:0] d);
    logic [15:0] r;
    spi({1'b1, a, d}, r);
  endtask : cfg

  // One full turn at one count per clock, then compare the drive's view
  task automatic sweep(input int dir, input int ppr, input int n);
    tick(400);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    for (int i = 1; i <= 4096; i++)
    begin
      angle_i = 12'(dir * i);
      tick(1);
    end
    tick(8);
    chk(24'(steps), 24'(6 * n));
    chk(24'(pos), 24'(dir * 4 * ppr));
    chk(24'(bad), 24'h000000);
    chk(24'(zrise), 24'h000001);
  endtask : sweep

  task automatic t_read(input logic [15:0] exp_low, input logic [15:0] exp_high);
    logic [15:0] r;
    angle_i = 12'hABD;
    field_mag_i = 8'h10;
    tick(2);
    chk(24'({field_low_o, field_high_o}), 24'(exp_low[3:2]));
    spi(16'h0000, r);
    chk(24'(r), 24'(exp_low));
    field_mag_i = 8'hF0;
    tick(2);
    chk(24'({field_low_o, field_high_o}), 24'(exp_high[3:2]));
    spi(16'h0000, r);
    chk(24'(r), 24'(exp_high));
    field_mag_i = 8'h80;
    angle_i = 12'h000;
    tick(1000);
  endtask : t_read

  task automatic t_poles;
    logic [11:0] a1;
    for (int n = 1; n <= 8; n++)
    begin
      cfg(ADDR_PP, 12'(n - 1));
      a1 = 12'((4096 + 6 * n - 1) / (6 * n));
      angle_i = a1;
      tick(3);
      chk(24'(uvw_o), 24'(exp_uvw(a1, n)));
      angle_i = a1 - 12'h001;
      tick(3);
      chk(24'(uvw_o), 24'(exp_uvw(a1 - 12'h001, n)));
      angle_i = 12'h000;
      sweep(1, 256, n);
    end
    ce_i = 1'b0;
    angle_i = 12'h800;
    tick(4);
    chk(24'(uvw_o), 24'h000005);
    ce_i = 1'b1;
    angle_i = 12'h000;
  endtask : t_poles

  task automatic t_abz;
    int ppr_list [3] = '{1, 5, 256};
    foreach (ppr_list[i])
    begin
      cfg(ADDR_PPR, 12'(ppr_list[i] - 1));
      sweep(1, ppr_list[i], 8);
      sweep(-1, ppr_list[i], 8);
    end
  endtask : t_abz

  task automatic t_commit;
    int k;
    chk(24'(uvw_n_o), 24'h000000);
    cfg(ADDR_ZERO, 12'h123);
    cfg(ADDR_CTL, 12'h003);
    chk(24'(wr_seen), 24'h000001);
    chk(wr_data, {1'b1, 8'hFF, 3'h7, 12'h123});
    angle_i = 12'h123;
    k = 0;
    while (z_o !== 1'b1 && k < 1200)
    begin
      tick(1);
      k++;
    end
    if (k == 1200)
    begin
      errors++;
      $display("CHECK FAILED at %0t: index never seen", $time);
      report_and_stop();
    end
    chk(24'({uvw_o, uvw_n_o}), 24'h00002A);
    angle_i = 12'h122;
    tick(3);
    chk(24'({uvw_o, uvw_n_o}), 24'h00000E);
    angle_i = 12'h000;
  endtask : t_commit

  task automatic t_fixed;
    cfg(ADDR_PP, 12'h007);
    cfg(ADDR_PPR, 12'h000);
    sweep(1, 256, 1);
    t_read(16'hABC2, 16'hABC2);
    cfg(ADDR_CTL, 12'h003);
    chk(24'({wr_seen[3:0], nvm_locked_o}), 24'h000003);
  endtask : t_fixed

  // Main sequence
  initial
  begin
    reset_dut(1'b0, 1'b0, 1'b0);
    t_read(16'hABD8, 16'hABD4);
    t_poles();
    t_abz();
    t_commit();
    reset_dut(1'b1, 1'b1, 1'b1);
    t_fixed();
    report_and_stop();
  end
endmodule : tb_angle_to_commutation_encoder
